// file: pkg/rxhw_pkg.sv
// Constants and types for the received-packet header writer.
// Assumes a byte-wide buffer write port addressed from the packet start.
package rxhw_pkg;
  localparam int          HDR_BYTES        = 8;
  localparam logic [10:0] OFS_EP_STAT      = 11'h000;
  localparam logic [10:0] OFS_PID          = 11'h001;
  localparam logic [10:0] OFS_FADDR        = 11'h002;
  localparam logic [10:0] OFS_RSVD         = 11'h003;
  localparam logic [10:0] OFS_FRM_LO       = 11'h004;
  localparam logic [10:0] OFS_FRM_HI       = 11'h005;
  localparam logic [10:0] OFS_CNT_LO       = 11'h006;
  localparam logic [10:0] OFS_CNT_HI       = 11'h007;
  localparam logic [10:0] OFS_PAYLOAD      = 11'h008;
  localparam int          BIT_REP_TOG      = 5;
  localparam int          BIT_RX_TOG       = 6;
  localparam int          BIT_CRC_ERR      = 7;
  localparam logic [7:0]  RSVD_VALUE       = 8'h00;
  localparam logic [10:0] MAX_PAYLOAD      = 11'h500;
  localparam logic [31:0] APB_STAT         = 32'h0000_0000;
  localparam logic [31:0] APB_MASK         = 32'h0000_0004;
  localparam logic [31:0] APB_LAST         = 32'h0000_0008;
  localparam logic [31:0] APB_TOG          = 32'h0000_000C;
  localparam int          IRQ_DONE         = 0;
  localparam int          IRQ_CRC          = 1;
  localparam int          IRQ_REPTOG       = 2;
  localparam int          IRQ_OVF          = 3;
  localparam logic [3:0]  STAT_RESET       = 4'h0;

  typedef enum logic [1:0] {
    RXHW_IDLE = 2'b00,
    RXHW_HDR  = 2'b01,
    RXHW_DATA = 2'b11,
    RXHW_CNT  = 2'b10
  } rxhw_state_t;
endpackage : rxhw_pkg

// file: design/rxhw_toggle_mem.sv
// Per-endpoint memory of the last received data toggle.
// Read data come out of a register one cycle after the address.
`timescale 1ns/1ns
`default_nettype none
module rxhw_toggle_mem #(
  parameter int EPS = 16
) (
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic [$clog2(EPS)-1:0] raddr,
  output logic                        rdata,
  input  wire logic                   we,
  input  wire logic [$clog2(EPS)-1:0] waddr,
  input  wire logic                   wdata,
  input  wire logic                   clr,
  output logic [EPS-1:0]              all_bits
);
  logic [EPS-1:0] mem_r;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      mem_r <= '0;
    else if (clr)
      mem_r <= '0;
    else if (we)
      mem_r[waddr] <= wdata;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rdata <= 1'b0;
    else
      rdata <= mem_r[raddr];
  end

  assign all_bits = mem_r;
endmodule : rxhw_toggle_mem
`default_nettype wire

// file: design/rxhw_writer.sv
// Received-packet header writer: builds the eight-byte header and stores payload.
// Assumes a serial engine handing over decoded fields and bytes on pclk.
`timescale 1ns/1ns
`default_nettype none
module rxhw_writer #(
  parameter int EPS = 16
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        pkt_start,
  input  wire logic [3:0]  pkt_endpoint,
  input  wire logic [3:0]  pkt_pid,
  input  wire logic [6:0]  received_function_address,
  input  wire logic [15:0] pkt_frame,
  input  wire logic        pkt_toggle,
  input  wire logic        rx_byte_valid,
  input  wire logic [7:0]  rx_byte,
  input  wire logic        pkt_end,
  input  wire logic        pkt_crc_bad,
  output logic             buf_we,
  output logic [10:0]      buf_addr,
  output logic [7:0]       buf_wdata,
  output logic             pkt_done,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq
);
  rxhw_pkg::rxhw_state_t state_r;
  logic [2:0]  hdr_idx_r;
  logic [10:0] count_r;
  logic [3:0]  ep_r;
  logic [3:0]  pid_r;
  logic [6:0]  faddr_r;
  logic [15:0] frame_r;
  logic        tog_r;
  logic        crc_r;
  logic        end_seen_r;
  logic        prev_tog;
  logic        rep_tog;
  logic [1:0]  cnt_idx_r;
  logic [3:0]  stat_r;
  logic [3:0]  mask_r;
  logic [15:0] last_hdr_r;
  logic [EPS-1:0] tog_bits;
  logic [3:0]  ev;
  logic        apb_wr;
  logic        apb_rd;
  logic        addr_ok;

  localparam int BIT_REP = rxhw_pkg::BIT_REP_TOG;

  function automatic logic [7:0] hdr_byte(input logic [2:0] idx, input logic rep);
    logic [7:0] b;
    b = rxhw_pkg::RSVD_VALUE;
    unique case (idx)
      3'h0: b = {crc_r, tog_r, rep, 1'b0, ep_r};
      3'h1: b = {4'h0, pid_r};
      3'h2: b = {1'b0, faddr_r};
      3'h3: b = rxhw_pkg::RSVD_VALUE;
      3'h4: b = frame_r[7:0];
      3'h5: b = frame_r[15:8];
      default: b = rxhw_pkg::RSVD_VALUE;
    endcase
    return b;
  endfunction

  // Previous toggle of this endpoint; equality means the host repeated data.
  assign rep_tog = (tog_r == prev_tog);

  rxhw_toggle_mem #(.EPS(EPS)) u_tog (
    .pclk     (pclk),
    .presetn  (presetn),
    .raddr    (pkt_endpoint[$clog2(EPS)-1:0]),
    .rdata    (prev_tog),
    .we       (state_r == rxhw_pkg::RXHW_HDR && hdr_idx_r == 3'h5),
    .waddr    (ep_r[$clog2(EPS)-1:0]),
    .wdata    (tog_r),
    .clr      (1'b0),
    .all_bits (tog_bits)
  );

  // Packet sequencer: header bytes, then payload, then the byte count.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_r    <= rxhw_pkg::RXHW_IDLE;
      hdr_idx_r  <= 3'h0;
      cnt_idx_r  <= 2'h0;
      count_r    <= 11'h000;
      ep_r       <= 4'h0;
      pid_r      <= 4'h0;
      faddr_r    <= 7'h00;
      frame_r    <= 16'h0000;
      tog_r      <= 1'b0;
      crc_r      <= 1'b0;
      end_seen_r <= 1'b0;
    end
    else
    begin
      unique case (state_r)
        rxhw_pkg::RXHW_IDLE:
        begin
          if (pkt_start)
          begin
            ep_r       <= pkt_endpoint;
            pid_r      <= pkt_pid;
            faddr_r    <= received_function_address;
            frame_r    <= pkt_frame;
            tog_r      <= pkt_toggle;
            crc_r      <= 1'b0;
            end_seen_r <= 1'b0;
            hdr_idx_r  <= 3'h0;
            count_r    <= rxhw_pkg::OFS_PAYLOAD;
            state_r    <= rxhw_pkg::RXHW_HDR;
          end
        end
        rxhw_pkg::RXHW_HDR:
        begin
          // Payload arriving meanwhile is not expected; the engine waits.
          if (pkt_end)
          begin
            end_seen_r <= 1'b1;
            crc_r      <= pkt_crc_bad;
          end
          hdr_idx_r <= hdr_idx_r + 3'h1;
          if (hdr_idx_r == 3'h5)
          begin
            state_r   <= (end_seen_r || pkt_end) ? rxhw_pkg::RXHW_CNT : rxhw_pkg::RXHW_DATA;
            cnt_idx_r <= 2'h0;
          end
        end
        rxhw_pkg::RXHW_DATA:
        begin
          if (rx_byte_valid && count_r < rxhw_pkg::MAX_PAYLOAD + rxhw_pkg::OFS_PAYLOAD)
            count_r <= count_r + 11'h001;
          if (pkt_end)
          begin
            crc_r     <= pkt_crc_bad;
            state_r   <= rxhw_pkg::RXHW_CNT;
            cnt_idx_r <= 2'h0;
          end
        end
        rxhw_pkg::RXHW_CNT:
        begin
          cnt_idx_r <= cnt_idx_r + 2'h1;
          if (cnt_idx_r == 2'h2)
            state_r <= rxhw_pkg::RXHW_IDLE;
        end
      endcase
    end
  end

  // Buffer write port; byte 0 is rewritten at the end with the CRC result.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      buf_we    <= 1'b0;
      buf_addr  <= 11'h000;
      buf_wdata <= 8'h00;
    end
    else
    begin
      buf_we <= 1'b0;
      if (state_r == rxhw_pkg::RXHW_HDR)
      begin
        buf_we    <= 1'b1;
        buf_addr  <= {8'h00, hdr_idx_r};
        buf_wdata <= hdr_byte(hdr_idx_r, rep_tog);
      end
      else if (state_r == rxhw_pkg::RXHW_DATA && rx_byte_valid &&
               count_r < rxhw_pkg::MAX_PAYLOAD + rxhw_pkg::OFS_PAYLOAD)
      begin
        buf_we    <= 1'b1;
        buf_addr  <= count_r;
        buf_wdata <= rx_byte;
      end
      else if (state_r == rxhw_pkg::RXHW_CNT)
      begin
        buf_we <= 1'b1;
        unique case (cnt_idx_r)
          2'h0:
          begin
            buf_addr  <= rxhw_pkg::OFS_CNT_LO;
            buf_wdata <= count_r[7:0];
          end
          2'h1:
          begin
            buf_addr  <= rxhw_pkg::OFS_CNT_HI;
            buf_wdata <= {5'h00, count_r[10:8]};
          end
          default:
          begin
            buf_addr  <= rxhw_pkg::OFS_EP_STAT;
            buf_wdata <= {crc_r, tog_r, last_hdr_r[BIT_REP], 1'b0, ep_r};
          end
        endcase
      end
    end
  end

  // Snapshot of the last header byte 0 and the low byte of the byte count for software.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      last_hdr_r <= 16'h0000;
      pkt_done   <= 1'b0;
    end
    else
    begin
      pkt_done <= (state_r == rxhw_pkg::RXHW_CNT && cnt_idx_r == 2'h2);
      if (state_r == rxhw_pkg::RXHW_HDR && hdr_idx_r == 3'h0)
        last_hdr_r[7:0] <= hdr_byte(3'h0, rep_tog);
      if (state_r == rxhw_pkg::RXHW_CNT && cnt_idx_r == 2'h2)
      begin
        last_hdr_r[7]      <= crc_r;
        last_hdr_r[15:8]   <= count_r[7:0];
      end
    end
  end

  // Events: done, CRC error, repeated toggle, payload overflow.
  assign ev[rxhw_pkg::IRQ_DONE]   = state_r == rxhw_pkg::RXHW_CNT && cnt_idx_r == 2'h2;
  assign ev[rxhw_pkg::IRQ_CRC]    = ev[rxhw_pkg::IRQ_DONE] && crc_r;
  assign ev[rxhw_pkg::IRQ_REPTOG] = state_r == rxhw_pkg::RXHW_HDR && hdr_idx_r == 3'h0 && rep_tog;
  assign ev[rxhw_pkg::IRQ_OVF]    = state_r == rxhw_pkg::RXHW_DATA && rx_byte_valid &&
                                    count_r >= rxhw_pkg::MAX_PAYLOAD + rxhw_pkg::OFS_PAYLOAD;

  assign apb_wr  = psel && penable && pwrite;
  assign apb_rd  = psel && !penable && !pwrite;
  assign addr_ok = paddr == rxhw_pkg::APB_STAT || paddr == rxhw_pkg::APB_MASK ||
                   paddr == rxhw_pkg::APB_LAST || paddr == rxhw_pkg::APB_TOG;

  // Sticky status; a new event wins over a write-one clear.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      stat_r <= rxhw_pkg::STAT_RESET;
    else if (apb_wr && paddr == rxhw_pkg::APB_STAT)
      stat_r <= (stat_r & ~pwdata[3:0]) | ev;
    else
      stat_r <= stat_r | ev;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      mask_r <= 4'h0;
    else if (apb_wr && paddr == rxhw_pkg::APB_MASK)
      mask_r <= pwdata[3:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq <= 1'b0;
    else
      irq <= |(stat_r & mask_r);
  end

  // Zero-wait APB slave: read data registered in setup, ready in access.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !addr_ok;
      if (apb_rd)
      begin
        if (paddr == rxhw_pkg::APB_STAT)
          prdata <= {28'h0, stat_r};
        else if (paddr == rxhw_pkg::APB_MASK)
          prdata <= {28'h0, mask_r};
        else if (paddr == rxhw_pkg::APB_LAST)
          prdata <= {16'h0, last_hdr_r};
        else if (paddr == rxhw_pkg::APB_TOG)
          prdata <= {{(32-EPS){1'b0}}, tog_bits};
        else
          prdata <= 32'h0000_0000;
      end
    end
  end

  AST_HDR_LEN: assert property (@(posedge pclk) disable iff (!presetn)
    (state_r == rxhw_pkg::RXHW_IDLE && pkt_start) |=> (state_r == rxhw_pkg::RXHW_HDR) [*6])
    else $error("Header phase not six cycles.");
  AST_HDR_ADDR: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(state_r == rxhw_pkg::RXHW_HDR) |=> buf_we && buf_addr == 11'h000)
    else $error("Header not started at offset zero.");
  AST_CNT_HI: assert property (@(posedge pclk) disable iff (!presetn)
    (buf_we && buf_addr == rxhw_pkg::OFS_CNT_HI) |-> buf_wdata[7:3] == 5'h00)
    else $error("Byte count high bits not zero.");
  AST_CNT_LO: assert property (@(posedge pclk) disable iff (!presetn)
    (state_r == rxhw_pkg::RXHW_CNT && cnt_idx_r == 2'h0) |=>
      buf_addr == rxhw_pkg::OFS_CNT_LO && buf_wdata == $past(count_r[7:0]))
    else $error("Byte count low byte wrong.");
  AST_PAYLOAD: assert property (@(posedge pclk) disable iff (!presetn)
    (buf_we && $past(state_r) == rxhw_pkg::RXHW_DATA) |-> buf_addr >= rxhw_pkg::OFS_PAYLOAD)
    else $error("Payload below offset eight.");
  AST_REP: assert property (@(posedge pclk) disable iff (!presetn)
    (state_r == rxhw_pkg::RXHW_HDR && hdr_idx_r == 3'h0) |=>
      buf_wdata[BIT_REP] == ($past(tog_r) == $past(prev_tog)))
    else $error("Repeated toggle flag wrong.");
  AST_TOG: assert property (@(posedge pclk) disable iff (!presetn)
    (buf_we && buf_addr == 11'h000) |-> buf_wdata[rxhw_pkg::BIT_RX_TOG] == tog_r
      && buf_wdata[4] == 1'b0)
    else $error("Received toggle bit wrong.");
  AST_CRC: assert property (@(posedge pclk) disable iff (!presetn)
    (state_r == rxhw_pkg::RXHW_DATA && pkt_end && pkt_crc_bad) |-> ##4
      buf_addr == 11'h000 && buf_wdata[rxhw_pkg::BIT_CRC_ERR])
    else $error("CRC flag not written.");
  AST_IRQ: assert property (@(posedge pclk) disable iff (!presetn)
    |(stat_r & mask_r) |=> irq)
    else $error("Interrupt not raised.");
  COV_PKT: cover property (@(posedge pclk) disable iff (!presetn) pkt_done);
  COV_CRC: cover property (@(posedge pclk) disable iff (!presetn) ev[rxhw_pkg::IRQ_CRC]);
  COV_REP: cover property (@(posedge pclk) disable iff (!presetn) ev[rxhw_pkg::IRQ_REPTOG]);
endmodule : rxhw_writer
`default_nettype wire

// file: testbench/rxhw_host_model.sv
// Behavioural host and serial engine that hand decoded packets to the header writer.
// Assumes send() is called from a process that runs on the rising edge of pclk.
`timescale 1ns/1ns
`default_nettype none
module rxhw_host_model (
  input  wire logic         pclk,
  output logic              pkt_start,
  output logic [3:0]        pkt_endpoint,
  output logic [3:0]        pkt_pid,
  output logic [6:0]        received_function_address,
  output logic [15:0]       pkt_frame,
  output logic              pkt_toggle,
  output logic              rx_byte_valid,
  output logic [7:0]        rx_byte,
  output logic              pkt_end,
  output logic              pkt_crc_bad
);
  initial
  begin
    {pkt_start, pkt_endpoint, pkt_pid, received_function_address, pkt_frame} = '0;
    {pkt_toggle, rx_byte_valid, rx_byte, pkt_end, pkt_crc_bad} = '0;
  end

  // Fields and data are inverted once no longer qualified, so stale values never match.
  task automatic send(input logic [3:0] ep, input logic [3:0] pid, input logic [6:0] fa,
                      input logic [15:0] fr, input logic tg, input logic cb, input int gap,
                      input logic [7:0] d[$]);
    @(posedge pclk);
    pkt_start <= 1'b1;
    pkt_endpoint <= ep;
    pkt_pid <= pid;
    received_function_address <= fa;
    pkt_frame <= fr;
    pkt_toggle <= tg;
    @(posedge pclk);
    pkt_start <= 1'b0;
    pkt_endpoint <= ~ep;
    pkt_pid <= ~pid;
    received_function_address <= ~fa;
    pkt_frame <= ~fr;
    pkt_toggle <= ~tg;
    repeat (6) @(posedge pclk);
    foreach (d[i])
    begin
      rx_byte_valid <= 1'b1;
      rx_byte <= d[i];
      @(posedge pclk);
      if (gap > 0)
      begin
        rx_byte_valid <= 1'b0;
        rx_byte <= ~d[i];
        repeat (gap) @(posedge pclk);
      end
    end
    rx_byte_valid <= 1'b0;
    rx_byte <= ~rx_byte;
    pkt_end <= 1'b1;
    pkt_crc_bad <= cb;
    @(posedge pclk);
    pkt_end <= 1'b0;
    pkt_crc_bad <= ~cb;
  endtask
endmodule // rxhw_host_model
`default_nettype wire

// file: testbench/rxhw_writer_test.sv
// Self-checking bench for the received-packet header writer.
// Assumes the host model drives the packet side and APB reaches the registers.
`timescale 1ns/1ns
`default_nettype none
module rxhw_writer_test;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] paddr = '0, pwdata = '0, prdata, seed = 32'h0001_0588, r;
  logic pkt_start, pkt_toggle, rx_byte_valid, pkt_end, pkt_crc_bad, e;
  logic [3:0] pkt_endpoint, pkt_pid;
  logic [6:0] received_function_address;
  logic [15:0] pkt_frame, prev = '0;
  logic [7:0] rx_byte, buf_wdata, mem [0:2047];
  logic buf_we, pkt_done, pready, pslverr, irq, done_seen;
  logic [10:0] buf_addr;
  int n_errors = 0, checks = 0, wr_cnt;
  logic [7:0] big[$];

  initial forever #5 pclk = ~pclk;

  rxhw_host_model rxhw_host_model_inst (.pclk(pclk), .pkt_start(pkt_start),
    .pkt_endpoint(pkt_endpoint), .pkt_pid(pkt_pid), .pkt_frame(pkt_frame),
    .received_function_address(received_function_address), .pkt_toggle(pkt_toggle),
    .rx_byte_valid(rx_byte_valid), .rx_byte(rx_byte), .pkt_end(pkt_end),
    .pkt_crc_bad(pkt_crc_bad));

  rxhw_writer #(.EPS(16)) rxhw_writer_inst (.pclk(pclk), .presetn(presetn),
    .pkt_start(pkt_start), .pkt_endpoint(pkt_endpoint), .pkt_pid(pkt_pid),
    .received_function_address(received_function_address), .pkt_frame(pkt_frame),
    .pkt_toggle(pkt_toggle), .rx_byte_valid(rx_byte_valid), .rx_byte(rx_byte),
    .pkt_end(pkt_end), .pkt_crc_bad(pkt_crc_bad), .buf_we(buf_we), .buf_addr(buf_addr),
    .buf_wdata(buf_wdata), .pkt_done(pkt_done), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq));

  always @(posedge pclk)
  begin
    if (buf_we === 1'b1)
    begin
      mem[buf_addr] <= buf_wdata;
      wr_cnt <= wr_cnt + 1;
    end
    if (pkt_done === 1'b1)
      done_seen <= 1'b1;
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (int i = 0; i <= 20; i++)
    begin
      @(posedge pclk);
      if (pready === 1'b1)
        break;
      if (i == 20)
      begin
        n_errors++;
        test_done();
      end
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Waits, with a bound, until the monitor has seen the packet record completed.
  task automatic wait_done();
    for (int i = 0; i <= 100 && done_seen !== 1'b1; i++)
    begin
      @(posedge pclk);
      if (i == 100)
      begin
        n_errors++;
        test_done();
      end
    end
  endtask

  // Sends one packet and compares the stored record with a header built here.
  task automatic run_pkt(input logic [3:0] ep, input int n, input logic tg, input logic cb,
                         input int gap);
    logic [7:0] d[$];
    logic [3:0] pid;
    logic [6:0] fa;
    logic [15:0] fr;
    logic rep;
    logic [10:0] cnt;
    pid = rnd();
    fa = rnd();
    fr = rnd();
    for (int i = 0; i < n; i++)
      d.push_back(8'(rnd()));
    rep = (tg == prev[ep]);
    prev[ep] = tg;
    cnt = 11'(n + 8);
    done_seen = 1'b0;
    wr_cnt = 0;
    rxhw_host_model_inst.send(ep, pid, fa, fr, tg, cb, gap, d);
    wait_done();
    chk("byte0", 32'(mem[0]), 32'({cb, tg, rep, 1'b0, ep}));
    chk("byte1", 32'(mem[1]), 32'({4'h0, pid}));
    chk("byte2", 32'(mem[2]), 32'({1'b0, fa}));
    chk("byte3", 32'(mem[3]), 32'(rxhw_pkg::RSVD_VALUE));
    chk("frame", 32'({mem[5], mem[4]}), 32'(fr));
    chk("count", 32'({mem[7], mem[6]}), 32'({5'h00, cnt}));
    foreach (d[i])
      chk("payload", 32'(mem[8 + i]), 32'(d[i]));
    if (n > 0)
      chk("last", 32'(mem[cnt - 1]), 32'(d[n - 1]));
    chk("writes", wr_cnt, n + 9);
  endtask

  initial
  begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    apb(1'b0, rxhw_pkg::APB_STAT, '0);
    chk("status reset", r, 32'h0000_0000);
    apb(1'b0, rxhw_pkg::APB_MASK, '0);
    chk("mask reset", r, 32'h0000_0000);
    apb(1'b0, 32'h0000_0010, '0);
    chk("unmapped err", 32'(e), 32'h0000_0001);
    chk("unmapped data", r, 32'h0000_0000);
    $display("test registers done");
    run_pkt(4'h0, 0, 1'b0, 1'b0, 0);
    run_pkt(4'h0, 1, 1'b1, 1'b1, 2);
    run_pkt(4'h0, 1, 1'b1, 1'b0, 0);
    run_pkt(4'hF, 64, 1'b0, 1'b0, 0);
    $display("test corner packets done");
    for (int k = 0; k < 20; k++)
      run_pkt(4'(rnd()), int'(rnd() % 40), 1'(rnd()), 1'(rnd()), int'(rnd() % 3));
    $display("test random packets done");
    apb(1'b1, rxhw_pkg::APB_STAT, 32'h0000_000F);
    run_pkt(4'h3, 2, prev[3], 1'b1, 0);
    apb(1'b0, rxhw_pkg::APB_STAT, '0);
    chk("status", r, 32'h0000_0007);
    chk("irq masked", 32'(irq), 32'h0000_0000);
    apb(1'b0, rxhw_pkg::APB_LAST, '0);
    chk("last record", r[15:0], {mem[6], mem[0]});
    apb(1'b0, rxhw_pkg::APB_TOG, '0);
    chk("toggles", r, 32'(prev));
    apb(1'b1, rxhw_pkg::APB_MASK, 32'h0000_0004);
    repeat (2) @(posedge pclk);
    chk("irq raised", 32'(irq), 32'h0000_0001);
    apb(1'b1, rxhw_pkg::APB_STAT, 32'h0000_0004);
    apb(1'b0, rxhw_pkg::APB_STAT, '0);
    chk("status w1c", r, 32'h0000_0003);
    repeat (2) @(posedge pclk);
    chk("irq cleared", 32'(irq), 32'h0000_0000);
    $display("test interrupt done");
    apb(1'b1, rxhw_pkg::APB_STAT, 32'h0000_000F);
    for (int i = 0; i < int'(rxhw_pkg::MAX_PAYLOAD) + 1; i++)
      big.push_back(8'(rnd()));
    done_seen = 1'b0;
    rxhw_host_model_inst.send(4'h1, 4'h1, 7'h01, 16'h0001, prev[1], 1'b0, 0, big);
    wait_done();
    apb(1'b0, rxhw_pkg::APB_STAT, '0);
    chk("overflow", 32'(r[rxhw_pkg::IRQ_OVF]), 32'h0000_0001);
    chk("clamped count", 32'({mem[7], mem[6]}), 32'(rxhw_pkg::MAX_PAYLOAD) + 32'h0000_0008);
    $display("test overflow done");
    test_done();
  end
endmodule // rxhw_writer_test
`default_nettype wire
